// ===== rtl/sgmii_pcs_map.svh
// register offsets, field positions, identity value and timing counts of the pcs control block
`ifndef SGMII_PCS_MAP_SVH
`define SGMII_PCS_MAP_SVH
`define OFS_ID 8'h00
`define OFS_RESET 8'h04
`define OFS_CTRL 8'h10
`define OFS_STAT 8'h14
`define OFS_LADV 8'h18
`define OFS_LNP 8'h1c
`define OFS_PADV 8'h20
`define OFS_PNP 8'h24
`define OFS_DCLR 8'h40
`define OFS_DSEL 8'h44
`define OFS_DRB 8'h48
`define BIT_FULL_RST 0
`define BIT_PATH_RST 1
`define BIT_AN_EN 0
`define BIT_AN_RESTART 1
`define BIT_QUICK_TMR 2
`define BIT_NP_LOADED 3
`define BIT_LOOPBACK 4
`define BIT_MASTER 5
`define BIT_COMMA 6
`define CLK_HZ 25000000
`define TMR_FIBER_US 10000
`define TMR_SGMII_NS 1600000
`define TMR_QUICK_NS 2000
`define CYC_FIBER ((`TMR_FIBER_US / 1000) * (`CLK_HZ / 1000))
`define CYC_SGMII ((`TMR_SGMII_NS / 40))
`define CYC_QUICK ((`TMR_QUICK_NS / 40))
`define DIAG_CLR_CYCLES 3
`define IDENT_VALUE 32'h0000_1000
`endif

// ===== rtl/sgmii_pcs_pkg.sv
// types for the pcs control block
package sgmii_pcs_pkg;
  typedef enum logic [2:0] {
    AN_OFF = 3'b000,
    AN_RESTART = 3'b001,
    AN_ABILITY = 3'b010,
    AN_ACK = 3'b011,
    AN_NEXT_PAGE = 3'b100,
    AN_IDLE_WAIT = 3'b101,
    AN_LINK_OK = 3'b110
  } an_state_t;
  typedef logic [1:0] htrans_t;
  typedef logic [2:0] hsize_t;
endpackage

// ===== rtl/sgmii_pcs_control.sv
// sgmii pcs control and status registers with negotiation and diagnostics
`timescale 1ns/100ps
`default_nettype none
`include "sgmii_pcs_map.svh"

// Summary of operation
// - full reset pulses, reads back zero
// - path reset holds tx/rx while set
// - comma force sends continuous K28.5
// - master mode uses local ability word
// - loopback routes tx back to rx
// - loaded flag cleared when page received
// - link timer 10ms/1.6ms or 2us quick
// - restart on one then zero write
// - negotiation runs only when enabled
// - page flag set on page, cleared by load
// - status mirrors signal detect and lock
// - done in bit 2, link bit 0
// - fault on half duplex gigabit, or fiber full duplex bit 5 not set in both words
// - local next page sent, fiber only
// - partner ability captured for readback
// - partner next page captured on receipt
// - diagnostic wipe clears all hold bits
// - selector picks diagnostic readback group
// - edge selector sets hold capture mode
// - reserved bits read zero
module sgmii_pcs_control (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire sgmii_pcs_pkg::htrans_t htrans_i,
  input wire logic hwrite_i,
  input wire sgmii_pcs_pkg::hsize_t hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic sgmii_mode_i,
  input wire logic fiber_signal_present_i,
  input wire logic lock_i,
  input wire logic rx_config_valid_i,
  input wire logic [15:0] rx_config_word_i,
  input wire logic rx_idle_i,
  output logic pcs_reset_o,
  output logic path_reset_o,
  output logic comma_force_o,
  output logic loopback_o,
  output logic tx_config_en_o,
  output logic [15:0] tx_config_word_o,
  output logic link_full_duplex_o,
  output logic [1:0] link_speed_o
);
  import sgmii_pcs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic full_rst;
    logic path_rst;
    logic an_en;
    logic an_restart;
    logic restart_req;
    logic quick_tmr;
    logic np_loaded;
    logic loopback;
    logic master;
    logic comma;
    logic [15:0] ladv;
    logic [15:0] lnp;
    logic [15:0] padv;
    logic [15:0] pnp;
    logic page_rx;
    logic an_done;
    logic an_fault;
    logic link_up;
    an_state_t an_st;
    logic [17:0] tmr;
    logic [1:0] edge_sel;
    logic [2:0] grp_sel;
    logic [1:0] wipe_cnt;
    logic [3:0] hold_prev;
    logic [3:0] hold;
    logic [15:0] cfg_prev;
    logic [15:0] tx_word;
    logic tx_cfg;
    logic duplex;
    logic [1:0] speed;
  } state_t;

  state_t r;
  state_t next_r;

  localparam logic [17:0] CYC_FIBER = 18'(`CYC_FIBER);
  localparam logic [17:0] CYC_SGMII = 18'(`CYC_SGMII);
  localparam logic [17:0] CYC_QUICK = 18'(`CYC_QUICK);

  logic [17:0] tmr_len;
  logic [3:0] hold_now;
  logic [3:0] hold_hit;
  logic [15:0] ab_src;
  logic ab_req;
  logic bus_go;

  always_comb begin
    if (r.quick_tmr) begin
      tmr_len = CYC_QUICK;
    end else if (sgmii_mode_i) begin
      tmr_len = CYC_SGMII;
    end else begin
      tmr_len = CYC_FIBER;
    end
  end

  assign hold_now = {lock_i, fiber_signal_present_i, rx_config_valid_i, rx_idle_i};
  assign bus_go = hsel_i & hready_i & htrans_i[1];

  always_comb begin
    if (r.edge_sel == 2'h1) begin
      hold_hit = hold_now & ~r.hold_prev;
    end else if (r.edge_sel == 2'h2) begin
      hold_hit = ~hold_now & r.hold_prev;
    end else if (r.edge_sel == 2'h3) begin
      hold_hit = hold_now ^ r.hold_prev;
    end else begin
      hold_hit = hold_now;
    end
  end

  // master takes speed and duplex from own word, slave from partner
  assign ab_src = r.master ? r.ladv : r.padv;
  assign ab_req = r.restart_req;

  always_comb begin
    next_r = r;
    next_r.full_rst = 1'b0;
    // ---------------------------------------------------------------
    // ahb-lite slave: address phase latched, data phase completes
    // ---------------------------------------------------------------
    next_r.wr_pend = bus_go & hwrite_i;
    next_r.rd_pend = bus_go & ~hwrite_i;
    if (bus_go) begin
      next_r.addr = haddr_i[7:0];
    end
    if (r.wr_pend) begin
      if (r.addr == `OFS_RESET) begin
        next_r.full_rst = hwdata_i[`BIT_FULL_RST];
        next_r.path_rst = hwdata_i[`BIT_PATH_RST];
      end else if (r.addr == `OFS_CTRL) begin
        next_r.an_en = hwdata_i[`BIT_AN_EN];
        next_r.an_restart = hwdata_i[`BIT_AN_RESTART];
        if (r.an_restart & ~hwdata_i[`BIT_AN_RESTART]) begin
          next_r.restart_req = 1'b1;
        end
        next_r.quick_tmr = hwdata_i[`BIT_QUICK_TMR];
        if (hwdata_i[`BIT_NP_LOADED] & ~sgmii_mode_i) begin
          next_r.np_loaded = 1'b1;
          next_r.page_rx = 1'b0;
        end
        next_r.loopback = hwdata_i[`BIT_LOOPBACK];
        next_r.master = hwdata_i[`BIT_MASTER];
        next_r.comma = hwdata_i[`BIT_COMMA];
      end else if (r.addr == `OFS_LADV) begin
        next_r.ladv = hwdata_i[15:0];
      end else if (r.addr == `OFS_LNP) begin
        next_r.lnp = hwdata_i[15:0];
      end else if (r.addr == `OFS_DCLR) begin
        if (hwdata_i[0]) begin
          next_r.wipe_cnt = 2'(`DIAG_CLR_CYCLES);
        end
      end else if (r.addr == `OFS_DSEL) begin
        next_r.grp_sel = hwdata_i[6:4];
        next_r.edge_sel = hwdata_i[1:0];
      end
    end
    // ---------------------------------------------------------------
    // diagnostic hold capture
    // ---------------------------------------------------------------
    next_r.hold_prev = hold_now;
    if (r.wipe_cnt != 2'h0) begin
      next_r.wipe_cnt = r.wipe_cnt - 2'h1;
      next_r.hold = 4'h0;
    end else if (r.edge_sel == 2'h0) begin
      next_r.hold = hold_hit;
    end else begin
      next_r.hold = r.hold | hold_hit;
    end
    // ---------------------------------------------------------------
    // negotiation machine
    // ---------------------------------------------------------------
    next_r.cfg_prev = rx_config_word_i;
    if (r.tmr != 18'h0) begin
      next_r.tmr = r.tmr - 18'h1;
    end
    if (!r.an_en || r.path_rst) begin
      next_r.an_st = AN_OFF;
      next_r.an_done = 1'b0;
      next_r.link_up = 1'b0;
      next_r.tx_cfg = 1'b0;
    end else if (ab_req) begin
      next_r.restart_req = 1'b0;
      next_r.an_st = AN_RESTART;
      next_r.tmr = tmr_len;
      next_r.an_done = 1'b0;
      next_r.link_up = 1'b0;
    end else begin
      case (r.an_st)
        AN_OFF: begin
          next_r.an_st = AN_RESTART;
          next_r.tmr = tmr_len;
        end
        AN_RESTART: begin
          next_r.tx_cfg = 1'b1;
          next_r.tx_word = 16'h0;
          if (r.tmr == 18'h0) begin
            next_r.an_st = AN_ABILITY;
            next_r.tx_word = r.ladv;
          end
        end
        AN_ABILITY: begin
          if (rx_config_valid_i && rx_config_word_i != 16'h0) begin
            next_r.padv = rx_config_word_i;
            next_r.tx_word = r.ladv | 16'h4000;
            next_r.an_st = AN_ACK;
            next_r.tmr = tmr_len;
          end
        end
        AN_ACK: begin
          if (r.tmr == 18'h0) begin
            if (!sgmii_mode_i && r.padv[15]) begin
              next_r.an_st = AN_NEXT_PAGE;
              next_r.tx_word = r.lnp;
            end else begin
              next_r.an_st = AN_IDLE_WAIT;
              next_r.tmr = tmr_len;
            end
          end
        end
        AN_NEXT_PAGE: begin
          if (rx_config_valid_i && rx_config_word_i != r.padv && r.np_loaded) begin
            next_r.pnp = rx_config_word_i;
            next_r.np_loaded = 1'b0;
            next_r.page_rx = 1'b1;
            next_r.an_st = AN_IDLE_WAIT;
            next_r.tmr = tmr_len;
          end
        end
        AN_IDLE_WAIT: begin
          next_r.tx_cfg = 1'b0;
          if (r.tmr == 18'h0 && rx_idle_i) begin
            next_r.an_st = AN_LINK_OK;
            next_r.an_done = 1'b1;
            next_r.link_up = sgmii_mode_i ? ab_src[15] | r.master : 1'b1;
            next_r.duplex = ab_src[12];
            next_r.speed = ab_src[11:10];
            if (sgmii_mode_i) begin
              next_r.an_fault = ~ab_src[12] & (ab_src[11:10] == 2'b10);
            end else begin
              next_r.an_fault = ~(r.ladv[5] & r.padv[5]);
            end
          end
        end
        AN_LINK_OK: begin
          // follow the master bit and the local word while the link stands
          next_r.duplex = ab_src[12];
          next_r.speed = ab_src[11:10];
          if (rx_config_valid_i && rx_config_word_i != r.padv) begin
            next_r.an_st = AN_RESTART;
            next_r.tmr = tmr_len;
            next_r.an_done = 1'b0;
            next_r.link_up = 1'b0;
          end
        end
        default: begin
          next_r.an_st = AN_OFF;
        end
      endcase
    end
    // ---------------------------------------------------------------
    // read data, reserved bits zero
    // ---------------------------------------------------------------
    next_r.rdata = 32'h0;
    if (bus_go & ~hwrite_i) begin
      if (haddr_i[7:0] == `OFS_ID) begin
        next_r.rdata = `IDENT_VALUE;
      end else if (haddr_i[7:0] == `OFS_RESET) begin
        next_r.rdata = {30'h0, r.path_rst, 1'b0};
      end else if (haddr_i[7:0] == `OFS_CTRL) begin
        next_r.rdata = {25'h0, r.comma, r.master, r.loopback, r.np_loaded,
                        r.quick_tmr, r.an_restart, r.an_en};
      end else if (haddr_i[7:0] == `OFS_STAT) begin
        next_r.rdata = {26'h0, fiber_signal_present_i, lock_i, r.page_rx,
                        r.an_done, r.an_fault, r.link_up};
      end else if (haddr_i[7:0] == `OFS_LADV) begin
        next_r.rdata = {16'h0, r.ladv};
      end else if (haddr_i[7:0] == `OFS_LNP) begin
        next_r.rdata = {16'h0, r.lnp};
      end else if (haddr_i[7:0] == `OFS_PADV) begin
        next_r.rdata = {16'h0, r.padv};
      end else if (haddr_i[7:0] == `OFS_PNP) begin
        next_r.rdata = {16'h0, r.pnp};
      end else if (haddr_i[7:0] == `OFS_DSEL) begin
        next_r.rdata = {25'h0, r.grp_sel, 2'h0, r.edge_sel};
      end else if (haddr_i[7:0] == `OFS_DRB) begin
        if (r.grp_sel == 3'h1) begin
          next_r.rdata = {28'h0, r.hold};
        end else if (r.grp_sel == 3'h3) begin
          next_r.rdata = {29'h0, r.an_st};
        end else if (r.grp_sel == 3'h5) begin
          next_r.rdata = {16'h0, r.tx_word};
        end else if (r.grp_sel == 3'h6) begin
          next_r.rdata = {24'h0, r.cfg_prev[7:0]};
        end else if (r.grp_sel == 3'h7) begin
          next_r.rdata = {24'h0, r.cfg_prev[15:8]};
        end else if (r.grp_sel == 3'h2) begin
          next_r.rdata = {31'h0, lock_i};
        end else if (r.grp_sel == 3'h4) begin
          next_r.rdata = {31'h0, r.tx_cfg};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (r.full_rst) begin
      // full reset clears all pcs state but keeps the bus answer clean
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      pcs_reset_o <= 1'b0;
      path_reset_o <= 1'b0;
      comma_force_o <= 1'b0;
      loopback_o <= 1'b0;
      tx_config_en_o <= 1'b0;
      tx_config_word_o <= 16'h0;
      link_full_duplex_o <= 1'b0;
      link_speed_o <= 2'h0;
    end else begin
      hrdata_o <= next_r.rdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      pcs_reset_o <= r.full_rst;
      path_reset_o <= r.path_rst | r.full_rst;
      comma_force_o <= r.comma;
      loopback_o <= r.loopback;
      tx_config_en_o <= r.tx_cfg & ~r.path_rst;
      tx_config_word_o <= r.tx_word;
      link_full_duplex_o <= r.duplex;
      link_speed_o <= r.speed;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_full_reset_pulse: assert property (r.full_rst |=> pcs_reset_o && !r.full_rst)
    else $error("full reset not pulsed");
  chk_path_reset_hold: assert property (r.path_rst |=> path_reset_o)
    else $error("path reset not held");
  chk_comma_force: assert property (r.comma |=> comma_force_o)
    else $error("comma force not driven");
  chk_loopback_out: assert property (r.loopback |=> loopback_o)
    else $error("loopback not driven");
  chk_np_before_page: assert property ($rose(r.page_rx) |-> !r.np_loaded)
    else $error("loaded flag still set at page receipt");
  chk_an_disabled: assert property (!r.an_en && !r.full_rst |=> r.an_st == AN_OFF)
    else $error("negotiation running while disabled");
  chk_quick_timer: assert property (r.quick_tmr |-> tmr_len == 18'd50)
    else $error("quick timer length wrong");
  chk_wipe_hold: assert property (r.wipe_cnt != 2'h0 && !r.full_rst |=> r.hold == 4'h0)
    else $error("hold bits not wiped");
  chk_done_link: assert property (r.link_up |-> r.an_done)
    else $error("link up without done");
  chk_sticky_hold: assert property (r.edge_sel != 2'h0 && r.wipe_cnt == 2'h0 && !r.full_rst
      && r.hold[0] |=> r.hold[0])
    else $error("edge hold bit lost");

  cov_negotiation_done: cover property (r.an_st == AN_IDLE_WAIT ##1 r.an_st == AN_LINK_OK);
  cov_next_page: cover property (r.an_st == AN_NEXT_PAGE ##1 r.page_rx);
  cov_restart: cover property (r.an_st == AN_LINK_OK ##1 r.an_st == AN_RESTART);
endmodule // sgmii_pcs_control
`default_nettype wire

// ===== tb/sgmii_link_partner.sv
// link partner model that answers configuration exchanges
`timescale 1ns/100ps
`default_nettype none
module sgmii_link_partner (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic reply_en_i,
  input wire logic slow_i,
  input wire logic [15:0] reply_word_i,
  input wire logic tx_config_en_i,
  output logic rx_config_valid_o,
  output logic [15:0] rx_config_word_o,
  output logic rx_idle_o
);
  logic [7:0] wait_cnt;
  // the word toggles outside valid so a stale value is never mistaken for a page
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 8'h00;
      rx_config_valid_o <= 1'b0;
      rx_config_word_o <= 16'h0000;
      rx_idle_o <= 1'b0;
    end else if (reply_en_i && tx_config_en_i) begin
      rx_idle_o <= 1'b0;
      if (wait_cnt < (slow_i ? 8'h28 : 8'h04)) begin
        wait_cnt <= wait_cnt + 8'h01;
        rx_config_valid_o <= 1'b0;
        rx_config_word_o <= ~rx_config_word_o;
      end else begin
        rx_config_valid_o <= 1'b1;
        rx_config_word_o <= reply_word_i;
      end
    end else begin
      wait_cnt <= 8'h00;
      rx_config_valid_o <= 1'b0;
      rx_config_word_o <= ~rx_config_word_o;
      rx_idle_o <= reply_en_i;
    end
  end
endmodule // sgmii_link_partner
`default_nettype wire

// ===== tb/tb_sgmii_pcs_control.sv
// self-checking bench for the pcs control block
`timescale 1ns/100ps
`default_nettype none
`include "sgmii_pcs_map.svh"
module tb_sgmii_pcs_control;
  import sgmii_pcs_pkg::*;
  logic ref_clk_i, rst_i, hsel, hwrite, hreadyout, hresp, sgmii_mode, sig_det, lock;
  logic rx_valid, rx_idle, pcs_reset, path_reset, comma_force, loopback, tx_cfg_en, full_dup;
  logic reply_en, slow;
  logic [1:0] speed;
  logic [15:0] rx_word, tx_cfg_word, reply_word;
  logic [31:0] haddr, hwdata, hrdata, r;
  htrans_t htrans;
  hsize_t hsize;
  int fails, cmp_count, cycles, pulses;
  sgmii_pcs_control dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .sgmii_mode_i(sgmii_mode), .fiber_signal_present_i(sig_det), .lock_i(lock),
    .rx_config_valid_i(rx_valid), .rx_config_word_i(rx_word), .rx_idle_i(rx_idle),
    .pcs_reset_o(pcs_reset), .path_reset_o(path_reset), .comma_force_o(comma_force),
    .loopback_o(loopback), .tx_config_en_o(tx_cfg_en), .tx_config_word_o(tx_cfg_word),
    .link_full_duplex_o(full_dup), .link_speed_o(speed));
  sgmii_link_partner partner (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reply_en_i(reply_en),
    .slow_i(slow), .reply_word_i(reply_word), .tx_config_en_i(tx_cfg_en),
    .rx_config_valid_o(rx_valid), .rx_config_word_o(rx_word), .rx_idle_o(rx_idle));
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hresp rides along every transfer; it must stay okay
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    // read data stands in the data phase and is taken at the edge that ends it
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic ochk(input logic [31:0] seen_now, input logic [31:0] exp);
    // a write reaches the pins one edge after it lands
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({28'h0, comma_force, loopback, full_dup, 1'b0} | {29'h0, speed, path_reset}, exp);
    @(posedge ref_clk_i);
  endtask
  task automatic poll(input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      ahb(1'b0, `OFS_STAT, 32'h0);
      n++;
    end while ((r & mask) != mask && n < 400);
  endtask
  // ------------------------------
  // clock, pulse count, timeout
  // ------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (pcs_reset === 1'b1) pulses++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    {hsel, hwrite, sgmii_mode, sig_det, lock, reply_en, slow} = 7'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    reply_word = 16'h0000;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(`OFS_ID, `IDENT_VALUE);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_STAT, 32'h0);
    rd(8'h30, 32'h0);
    chk({31'h0, tx_cfg_en}, 32'h0);
    $display("test reset values done");
    wr_ctrl_block();
    sig_det <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(`OFS_STAT, 32'h20);
    lock <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(`OFS_STAT, 32'h30);
    $display("test status mirror done");
    for (int i = 0; i < 32; i++) begin
      ahb(1'b1, `OFS_DSEL, {25'h0, i[4:2], 2'h0, i[1:0]});
      rd(`OFS_DSEL, {25'h0, i[4:2], 2'h0, i[1:0]});
    end
    ahb(1'b1, `OFS_DSEL, 32'h11);
    ahb(1'b1, `OFS_DCLR, 32'h1);
    ahb(1'b1, `OFS_DCLR, 32'h0);
    repeat (6) @(posedge ref_clk_i);
    lock <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    lock <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    lock <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    ahb(1'b0, `OFS_DRB, 32'h0);
    chk(r & 32'hffff0008, 32'h8);
    ahb(1'b1, `OFS_DCLR, 32'h1);
    ahb(1'b1, `OFS_DCLR, 32'h0);
    repeat (6) @(posedge ref_clk_i);
    ahb(1'b0, `OFS_DRB, 32'h0);
    chk(r & 32'h8, 32'h0);
    $display("test diagnostics done");
    // lock first, since status bits mean nothing before it
    sgmii_mode <= 1'b1;
    lock <= 1'b1;
    reply_word <= 16'hd801;
    reply_en <= 1'b1;
    ahb(1'b1, `OFS_LADV, 32'h4001);
    ahb(1'b1, `OFS_CTRL, 32'h5);
    poll(32'h5);
    chk(r & 32'h7, 32'h5);
    rd(`OFS_PADV, 32'hd801);
    ochk(32'h0, 32'h6);
    ahb(1'b1, `OFS_CTRL, 32'h25);
    ochk(32'h0, 32'h0);
    reply_word <= 16'hc801;
    slow <= 1'b1;
    ahb(1'b1, `OFS_CTRL, 32'h7);
    ahb(1'b1, `OFS_CTRL, 32'h5);
    @(posedge ref_clk_i);
    ahb(1'b0, `OFS_STAT, 32'h0);
    chk(r & 32'h4, 32'h0);
    poll(32'h2);
    chk(r & 32'h2, 32'h2);
    rd(`OFS_PADV, 32'hc801);
    $display("test negotiation done");
    // fiber mode with one next page; the partner answers it once it is on the line
    sgmii_mode <= 1'b0;
    reply_word <= 16'h8020;
    ahb(1'b1, `OFS_LADV, 32'h0020);
    ahb(1'b1, `OFS_CTRL, 32'hf);
    ahb(1'b1, `OFS_CTRL, 32'hd);
    while (tx_cfg_word !== 16'hffff) @(posedge ref_clk_i);
    reply_word <= 16'h1234;
    poll(32'h5);
    chk(r & 32'hf, 32'hd);
    rd(`OFS_PNP, 32'h1234);
    rd(`OFS_PADV, 32'h8020);
    rd(`OFS_CTRL, 32'h5);
    ahb(1'b1, `OFS_CTRL, 32'hd);
    rd(`OFS_STAT, 32'h35);
    $display("test next page done");
    ahb(1'b1, `OFS_RESET, 32'h1);
    rd(`OFS_RESET, 32'h0);
    rd(`OFS_LADV, 32'h0);
    chk(32'(pulses), 32'h1);
    $display("test full reset done");
    end_of_test();
  end
  task automatic wr_ctrl_block();
    ahb(1'b1, `OFS_CTRL, 32'hffffff74);
    rd(`OFS_CTRL, 32'h74);
    ochk(32'h0, 32'hc);
    ahb(1'b1, `OFS_LNP, 32'hffffffff);
    rd(`OFS_LNP, 32'hffff);
    ahb(1'b1, `OFS_CTRL, 32'h0);
    ochk(32'h0, 32'h0);
    ahb(1'b1, `OFS_RESET, 32'h2);
    ochk(32'h0, 32'h1);
    rd(`OFS_RESET, 32'h2);
    ahb(1'b1, `OFS_RESET, 32'h0);
    ochk(32'h0, 32'h0);
    $display("test control bits done");
  endtask
endmodule // tb_sgmii_pcs_control
`default_nettype wire
